// ### verilog/lpct_core.sv
`include "lpct_map.svh"

// Summary of operation
// R1 - Controller keeps bank open 37 to 8000 ns
// R2 - Same bank activates at least 59.2 ns apart
// R3 - Different bank activates at least 9.2 ns apart
// R4 - Activate to read or write 20 ns
// R5 - Precharge 18 ns, open plus precharge covers cycle
// R6 - After refresh only idle for 100 ns
// R7 - Precharge waits for write end plus recovery
// R8 - Autoclose write to activate waits data-in delay
// R9 - Read autoclose closes bank half burst later
// R10 - Write to read waits burst plus delay
// R11 - Stopped write to read waits one plus delay
// R12 - Controller holds mask high during write-to-read
// R13 - Precharge ends read, pins float after CL
// R14 - New read or write interrupts running burst; the core's read does not end a running write burst
// R15 - Read to write waits CL plus half burst
// R16 - Stopped read to write waits CL cycles
// R17 - Burst stop drops write data next clock on
// R18 - Masked input bytes never reach the array
// R19 - Refresh needs all banks closed, idle meanwhile
// R20 - Self refresh needs closed banks, idle after exit
// R21 - Mode program needs idle, two clocks apart
// R22 - Power down needs floating pins, exit one clock
// R23 - Deep sleep needs idle, exit needs reinitialising
// R24 - Controller issues 4096 refreshes per period
// R25 - Write with address bit ten autocloses bank
// R26 - Controller rounds times up, tracks banks
module lpct_core
  import lpct_pkg::*;
#(
  parameter int COL_W      = 4,
  parameter int FIFO_DEPTH = `LPCT_FIFO_DEP
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  input  wire logic        CKE,
  input  wire logic        CS_N,
  input  wire logic        RAS_N,
  input  wire logic        CAS_N,
  input  wire logic        WE_N,
  input  wire logic [1:0]  BA,
  input  wire logic [11:0] A,
  input  wire logic [7:0]  DM,
  input  wire logic [63:0] DQ_IN,
  output logic      [63:0] DQ_OUT,
  output logic             DQ_OE_N,
  output logic      [3:0]  BANK_OPEN,
  output logic             WR_OVERRUN
);
  localparam int IDX_W = COL_W + 2;
  localparam int DEPTH = 1 << IDX_W;
  localparam int ENT_W = IDX_W + 8 + 64;
  localparam int PIPE  = `LPCT_PIPE_LEN;

  typedef struct packed {
    lpct_pwr_t                pwr;
    logic [3:0]               open;
    logic [2:0]               cl;
    logic [2:0]               bl;
    logic [4:0]               wr_left;
    logic [1:0]               wr_bank;
    logic [COL_W-1:0]         wr_col;
    logic                     wr_auto;
    logic [4:0]               rd_left;
    logic [1:0]               rd_bank;
    logic [COL_W-1:0]         rd_col;
    logic [4:0]               ap_left;
    logic [1:0]               ap_bank;
    logic [PIPE-1:0]          pv;
    logic [PIPE-1:0][63:0]    pd;
    logic [63:0]              dq;
    logic                     oe_n;
    logic                     overrun;
    logic [DEPTH-1:0][63:0]   mem;
  } lpct_core_state_t;

  lpct_core_state_t s;
  lpct_core_state_t next_s;
  lpct_cmd_t        cmd;
  logic             go;
  logic             rd_fire;
  logic             wr_fire;
  logic             bst_fire;
  logic             pre_fire;
  logic             rd_stop;
  logic             rd_issue;
  logic             beat;
  logic             f_in_valid;
  logic             f_in_ready;
  logic             f_out_valid;
  logic [ENT_W-1:0] f_out;
  logic [IDX_W-1:0] d_idx;
  logic [7:0]       d_dm;
  logic [63:0]      d_data;
  logic [IDX_W-1:0] rd_idx;
  logic [1:0]       tap;
  logic [4:0]       half;

  always_comb begin
    cmd = CMD_NOP;
    case ({RAS_N, CAS_N, WE_N})
      3'b011:  cmd = CMD_ACT;
      3'b101:  cmd = CMD_READ;
      3'b100:  cmd = CMD_WRITE;
      3'b010:  cmd = CMD_PRE;
      3'b001:  cmd = CMD_REF;
      3'b000:  cmd = CMD_MRS;
      3'b110:  cmd = CMD_BST;
      default: cmd = CMD_NOP;
    endcase
    if (CS_N) begin
      cmd = CMD_NOP;
    end
  end

  always_comb begin
    case (s.bl)
      3'h1:    half = 5'h01;
      3'h2:    half = 5'h02;
      3'h3:    half = 5'h04;
      3'h4:    half = 5'h08;
      default: half = 5'h02;
    endcase
    case (s.cl)
      3'h2:    tap = 2'h0;
      3'h4:    tap = 2'h2;
      default: tap = 2'h1;
    endcase
  end

  assign go       = (s.pwr == PWR_ON) && CKE;
  assign rd_fire  = go && (cmd == CMD_READ);
  assign wr_fire  = go && (cmd == CMD_WRITE);
  assign bst_fire = go && (cmd == CMD_BST);
  assign pre_fire = go && (cmd == CMD_PRE);
  // R13 stop read
  assign rd_stop  = pre_fire || bst_fire || wr_fire;
  assign rd_issue = rd_fire || ((s.rd_left != '0) && !rd_stop);
  assign rd_idx   = rd_fire ? {BA, A[COL_W-1:0]} : {s.rd_bank, s.rd_col};
  assign beat     = (s.wr_left != '0);
  // R18 fully masked beat
  assign f_in_valid = beat && !(&DM);
  assign {d_idx, d_dm, d_data} = f_out;

  // Array port busy on read beats, so draining stalls then
  lpct_fifo #(
    .WIDTH (ENT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk       (CLK_SYS),
    .rst_n     (RSTN),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   ({s.wr_bank, s.wr_col, DM, DQ_IN}),
    .out_valid (f_out_valid),
    .out_ready (!rd_issue),
    .out_data  (f_out)
  );

  always_comb begin
    next_s    = s;
    next_s.pv = {s.pv[PIPE-2:0], rd_issue};
    next_s.pd = {s.pd[PIPE-2:0], s.mem[rd_idx]};
    next_s.dq   = s.pd[tap];
    next_s.oe_n = !s.pv[tap];
    if (s.rd_left != '0) begin
      next_s.rd_left = s.rd_left - 5'h01;
      next_s.rd_col  = COL_W'(s.rd_col + 1'b1);
    end
    if (rd_stop) begin
      next_s.rd_left = '0;
    end
    // R14 read restart
    if (rd_fire) begin
      next_s.rd_left = half - 5'h01;
      next_s.rd_bank = BA;
      next_s.rd_col  = COL_W'(A[COL_W-1:0] + 1'b1);
    end
    if (beat) begin
      next_s.wr_left = s.wr_left - 5'h01;
      next_s.wr_col  = COL_W'(s.wr_col + 1'b1);
      // R25 close after burst
      if ((s.wr_left == 5'h01) && s.wr_auto) begin
        next_s.open[s.wr_bank] = 1'b0;
      end
    end
    // R17 later data dropped
    if (bst_fire) begin
      next_s.wr_left = '0;
    end
    // R14 write restart
    if (wr_fire) begin
      next_s.wr_left = half;
      next_s.wr_bank = BA;
      next_s.wr_col  = A[COL_W-1:0];
      next_s.wr_auto = A[`LPCT_AUTO_BIT];
    end
    // R9 delayed read close
    if (s.ap_left != '0) begin
      next_s.ap_left = s.ap_left - 5'h01;
      if (s.ap_left == 5'h01) begin
        next_s.open[s.ap_bank] = 1'b0;
      end
    end
    if (rd_fire && A[`LPCT_AUTO_BIT]) begin
      next_s.ap_left = half;
      next_s.ap_bank = BA;
    end
    if (go && (cmd == CMD_ACT)) begin
      next_s.open[BA] = 1'b1;
    end
    if (pre_fire) begin
      if (A[`LPCT_AUTO_BIT]) begin
        next_s.open = '0;
      end else begin
        next_s.open[BA] = 1'b0;
      end
    end
    if (go && (cmd == CMD_MRS)) begin
      next_s.cl = A[`LPCT_CL_MSB:`LPCT_CL_LSB];
      next_s.bl = A[`LPCT_BL_MSB:`LPCT_BL_LSB];
    end
    case (s.pwr)
      PWR_ON: begin
        if (!CKE) begin
          if (cmd == CMD_REF) begin
            next_s.pwr = PWR_SELF;
          end else if (cmd == CMD_BST) begin
            next_s.pwr = PWR_DEEP;
          end else begin
            next_s.pwr = PWR_DOWN;
          end
        end
      end
      PWR_DOWN, PWR_SELF: begin
        if (CKE) begin
          next_s.pwr = PWR_ON;
        end
      end
      PWR_DEEP: begin
        // Banks close and mode returns to reset values, so mode must be programmed again
        if (CKE) begin
          next_s.pwr  = PWR_ON;
          next_s.open = '0;
          next_s.cl   = `LPCT_CL_RST;
          next_s.bl   = `LPCT_BL_RST;
        end
      end
      default: next_s.pwr = PWR_ON;
    endcase
    // R18 byte enables
    if (f_out_valid && !rd_issue) begin
      for (int i = 0; i < 8; i++) begin
        if (!d_dm[i]) begin
          next_s.mem[d_idx][i*8 +: 8] = d_data[i*8 +: 8];
        end
      end
    end
    if (f_in_valid && !f_in_ready) begin
      next_s.overrun = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      s      <= '0;
      s.cl   <= `LPCT_CL_RST;
      s.bl   <= `LPCT_BL_RST;
      s.oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign DQ_OUT     = s.dq;
  assign DQ_OE_N    = s.oe_n;
  assign BANK_OPEN  = s.open;
  assign WR_OVERRUN = s.overrun;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  property p_read_close;
    (rd_fire && A[`LPCT_AUTO_BIT] && (s.bl == 3'h2) && (BA == 2'h0))
      |-> ##3 !BANK_OPEN[0];
  endproperty
  a_read_close: assert property (p_read_close) // R9
    else $error("read autoclose did not close bank");

  property p_pre_float;
    (pre_fire && (s.cl == 3'h3)) ##1 (!rd_fire)[*2] |=> DQ_OE_N;
  endproperty
  a_pre_float: assert property (p_pre_float) // R13
    else $error("data pins still driven CL after precharge");

  property p_read_data;
    (rd_fire && (s.cl == 3'h3)) |-> ##3 !DQ_OE_N;
  endproperty
  a_read_data: assert property (p_read_data) // R14
    else $error("read data missing CL after read");

  property p_write_restart;
    (wr_fire && (s.bl == 3'h2)) ##1 wr_fire |=> (s.wr_left == 5'h02);
  endproperty
  a_write_restart: assert property (p_write_restart) // R14
    else $error("second write did not restart burst");

  property p_stop_drop;
    (bst_fire && beat) |=> !f_in_valid;
  endproperty
  a_stop_drop: assert property (p_stop_drop) // R17
    else $error("write data accepted after burst stop");

  property p_mask_drop;
    (beat && (&DM)) |-> !f_in_valid;
  endproperty
  a_mask_drop: assert property (p_mask_drop) // R18
    else $error("fully masked beat queued");

  property p_write_close;
    (wr_fire && A[`LPCT_AUTO_BIT] && (s.bl == 3'h2) && (BA == 2'h1))
      ##1 (!wr_fire && !bst_fire && (cmd != CMD_ACT))[*2]
      |=> !BANK_OPEN[1];
  endproperty
  a_write_close: assert property (p_write_close) // R25
    else $error("write autoclose did not close bank");

  c_read:  cover property (rd_fire ##[1:8] !DQ_OE_N);
  c_wrap:  cover property (wr_fire && A[`LPCT_AUTO_BIT]);
  c_self:  cover property (s.pwr == PWR_SELF);
  c_full:  cover property (!f_in_ready);

endmodule // lpct_core

// ### verilog/lpct_map.svh
`ifndef LPCT_MAP_SVH
`define LPCT_MAP_SVH

`define LPCT_CL_LSB    4
`define LPCT_CL_MSB    6
`define LPCT_BL_LSB    0
`define LPCT_BL_MSB    2
`define LPCT_CL_RST    3'h3
`define LPCT_BL_RST    3'h2
`define LPCT_AUTO_BIT  10
`define LPCT_PIPE_LEN  3
`define LPCT_FIFO_DEP  16

`endif

// ### verilog/lpct_pkg.sv
package lpct_pkg;

  typedef enum logic [1:0] {
    PWR_ON,
    PWR_DOWN,
    PWR_SELF,
    PWR_DEEP
  } lpct_pwr_t;

  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACT,
    CMD_READ,
    CMD_WRITE,
    CMD_PRE,
    CMD_REF,
    CMD_MRS,
    CMD_BST
  } lpct_cmd_t;

endpackage : lpct_pkg

// ### verilog/lpct_fifo.sv
module lpct_fifo
  import lpct_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [CW-1:0]               cnt;
  } lpct_fifo_state_t;

  lpct_fifo_state_t s;
  lpct_fifo_state_t next_s;
  logic             push;
  logic             pop;

  assign in_ready  = (s.cnt != CW'(DEPTH));
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data;
      // Wrap explicitly so non power of two depths work
      next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : AW'(s.wp + 1'b1);
    end
    if (pop) begin
      next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : AW'(s.rp + 1'b1);
    end
    if (push && !pop) begin
      next_s.cnt = CW'(s.cnt + 1'b1);
    end else if (pop && !push) begin
      next_s.cnt = CW'(s.cnt - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule // lpct_fifo

// ### bench/lpct_ctl_model.sv
module lpct_ctl_model
  import lpct_pkg::*;
(
  input  wire logic        clk,
  output logic             cke,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [1:0]       ba,
  output logic [11:0]      a,
  output logic [7:0]       dm,
  output logic [63:0]      dq_in
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int T_RCD = 2;
  localparam int T_RP  = 2;
  localparam int T_RC  = 6;
  localparam int T_WTR = 1;
  localparam logic [2:0] ENC [8] = '{3'h7, 3'h3, 3'h5, 3'h4,
                                     3'h2, 3'h1, 3'h0, 3'h6};

  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    ba = 2'h0;
    a = 12'h000;
    dm = 8'hFF;
    dq_in = 64'h0000_0000_0000_0000;
  end

  // Pins change just after the edge
  task automatic step(input lpct_cmd_t c, input logic [1:0] b,
                      input logic [11:0] ad, input logic [63:0] d,
                      input logic [7:0] m);
    @(posedge clk);
    #1;
    cs_n = (c == CMD_NOP);
    {ras_n, cas_n, we_n} = ENC[c];
    ba = b;
    a = ad;
    dq_in = d;
    dm = m;
  endtask

  task automatic power(input logic v);
    @(posedge clk);
    #1;
    cke = v;
  endtask

  task automatic idle(input int n);
    repeat (n) step(CMD_NOP, ~ba, ~a, ~dq_in, 8'hFF);
  endtask
endmodule // lpct_ctl_model

// ### bench/tb_lpddr_command_timing_rules.sv
module tb_lpddr_command_timing_rules
  import lpct_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [63:0] D0 = 64'h0123_4567_89AB_CDEF;
  localparam logic [63:0] D1 = 64'hFEDC_BA98_7654_3210;
  localparam logic [63:0] D2 = 64'h5A5A_0F0F_A5A5_F0F0;
  localparam logic [63:0] D3 = 64'h1111_2222_3333_4444;
  localparam logic [63:0] Z  = 64'h0000_0000_0000_0000;
  logic        CLK_SYS = 1'b0;
  logic        RSTN    = 1'b0;
  logic        CKE;
  logic        CS_N;
  logic        RAS_N;
  logic        CAS_N;
  logic        WE_N;
  logic [1:0]  BA;
  logic [11:0] A;
  logic [7:0]  DM;
  logic [63:0] DQ_IN;
  logic [63:0] DQ_OUT;
  logic        DQ_OE_N;
  logic [3:0]  BANK_OPEN;
  logic        WR_OVERRUN;
  int          errors = 0;
  int          total_checks = 0;

  always #5 CLK_SYS = ~CLK_SYS;

  lpct_ctl_model ctl (.clk(CLK_SYS), .cke(CKE), .cs_n(CS_N),
    .ras_n(RAS_N), .cas_n(CAS_N), .we_n(WE_N), .ba(BA), .a(A),
    .dm(DM), .dq_in(DQ_IN));

  lpct_core #(.COL_W(4), .FIFO_DEPTH(16)) uut (.CLK_SYS(CLK_SYS),
    .RSTN(RSTN), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N),
    .WE_N(WE_N), .BA(BA), .A(A), .DM(DM), .DQ_IN(DQ_IN),
    .DQ_OUT(DQ_OUT), .DQ_OE_N(DQ_OE_N), .BANK_OPEN(BANK_OPEN),
    .WR_OVERRUN(WR_OVERRUN));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic cmd(input lpct_cmd_t c, input logic [1:0] b,
                     input logic [11:0] ad);
    ctl.step(c, b, ad, ~DQ_IN, 8'hFF);
  endtask

  // Stop flag puts a burst stop on the first data beat
  task automatic wr(input logic [1:0] b, input logic [11:0] ad,
                    input logic [63:0] d0, input logic [63:0] d1,
                    input logic [7:0] m1, input logic stop);
    cmd(CMD_WRITE, b, ad);
    ctl.step(stop ? CMD_BST : CMD_NOP, b, ~ad, d0, 8'h00);
    ctl.step(CMD_NOP, ~b, ad, d1, m1);
  endtask

  task automatic rd_chk(input logic [11:0] ad, input logic [63:0] e0,
                        input logic [63:0] e1);
    cmd(CMD_READ, 2'h0, ad);
    ctl.idle(3);
    check(64'(DQ_OE_N), Z);
    check(DQ_OUT, e0);
    ctl.idle(1);
    check(DQ_OUT, e1);
    ctl.idle(1);
    check(64'(DQ_OE_N), 64'h1);
  endtask

  task automatic t_reset;
    check(64'(DQ_OE_N), 64'h1);
    check(DQ_OUT, Z);
    check(64'(BANK_OPEN), Z);
    check(64'(WR_OVERRUN), Z);
    $display("test reset done");
  endtask

  task automatic t_mask;
    cmd(CMD_ACT, 2'h0, 12'h123);
    ctl.idle(ctl.T_RCD);
    check(64'(BANK_OPEN), 64'h1);
    wr(2'h0, 12'h000, D0, D1, 8'h01, 1'b0);
    ctl.idle(ctl.T_WTR + 4);
    rd_chk(12'h000, D0, D1 & 64'hFFFF_FFFF_FFFF_FF00);
    $display("test mask done");
  endtask

  task automatic t_bst;
    wr(2'h0, 12'h004, D2, D3, 8'h00, 1'b1);
    ctl.idle(ctl.T_WTR + 4);
    rd_chk(12'h004, D2, Z);
    $display("test burst stop done");
  endtask

  task automatic t_pre;
    cmd(CMD_READ, 2'h0, 12'h000);
    cmd(CMD_PRE, 2'h0, 12'h000);
    ctl.idle(2);
    check(DQ_OUT, D0);
    ctl.idle(1);
    check(64'(DQ_OE_N), 64'h1);
    check(64'(BANK_OPEN), Z);
    ctl.idle(ctl.T_RP);
    $display("test precharge read done");
  endtask

  task automatic t_auto;
    cmd(CMD_ACT, 2'h1, 12'h055);
    ctl.idle(ctl.T_RCD);
    cmd(CMD_READ, 2'h1, 12'h400);
    ctl.idle(2);
    check(64'(BANK_OPEN), 64'h2);
    ctl.idle(1);
    check(64'(BANK_OPEN), Z);
    ctl.idle(ctl.T_RC);
    cmd(CMD_ACT, 2'h1, 12'h055);
    ctl.idle(ctl.T_RCD);
    wr(2'h1, 12'h400, D0, D1, 8'h00, 1'b0);
    check(64'(BANK_OPEN), 64'h2);
    ctl.idle(1);
    check(64'(BANK_OPEN), Z);
    $display("test autoclose done");
  endtask

  task automatic t_restart;
    ctl.step(CMD_WRITE, 2'h0, 12'h008, Z, 8'hFF);
    ctl.step(CMD_WRITE, 2'h0, 12'h00A, D1, 8'h00);
    ctl.step(CMD_NOP, 2'h0, 12'h000, D2, 8'hFF);
    ctl.step(CMD_NOP, 2'h0, 12'h000, D3, 8'h00);
    ctl.idle(5);
    rd_chk(12'h008, D1, Z);
    rd_chk(12'h00A, Z, D3);
    $display("test write restart done");
  endtask

  task automatic t_power;
    ctl.power(1'b0);
    cmd(CMD_ACT, 2'h2, 12'h000);
    ctl.power(1'b1);
    ctl.idle(1);
    check(64'(BANK_OPEN), Z);
    cmd(CMD_ACT, 2'h2, 12'h000);
    ctl.idle(1);
    check(64'(BANK_OPEN), 64'h4);
    cmd(CMD_BST, 2'h0, 12'h000);
    ctl.power(1'b0);
    ctl.power(1'b1);
    ctl.idle(1);
    check(64'(BANK_OPEN), Z);
    $display("test power states done");
  endtask

  task automatic t_overrun;
    cmd(CMD_MRS, 2'h0, 12'h034);
    ctl.idle(2);
    // Reads starve the drain so the queue fills
    repeat (3) begin
      ctl.step(CMD_WRITE, 2'h3, 12'h000, D0, 8'h00);
      repeat (7) ctl.step(CMD_READ, 2'h3, 12'h000, D1, 8'h00);
    end
    ctl.idle(24);
    check(64'(WR_OVERRUN), 64'h1);
    $display("test overrun done");
  endtask

  task automatic t_midreset;
    cmd(CMD_ACT, 2'h3, 12'h000);
    ctl.idle(1);
    @(posedge CLK_SYS);
    #1;
    RSTN = 1'b0;
    repeat (2) @(posedge CLK_SYS);
    #1;
    RSTN = 1'b1;
    check(64'(BANK_OPEN), Z);
    check(64'(WR_OVERRUN), Z);
    check(64'(DQ_OE_N), 64'h1);
    cmd(CMD_ACT, 2'h1, 12'h000);
    ctl.idle(1);
    check(64'(BANK_OPEN), 64'h2);
    $display("test mid reset done");
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge CLK_SYS);
    #1;
    RSTN = 1'b1;
    t_reset();
    t_mask();
    t_bst();
    t_pre();
    t_auto();
    t_restart();
    t_power();
    t_overrun();
    t_midreset();
    give_verdict();
  end
endmodule // tb_lpddr_command_timing_rules
